// >>> design/kwd_watchdog.v
// keyed watchdog timer top: apb slave, control registers, counter, reset pulse
//
// Chosen here: the register addresses and the APB register port.
`include "kwd_defines.vh"

module kwd_watchdog #(
  parameter OSC_DIV = `KWD_OSC_DIV
) (
  input wire clk_in, // system clock, 125 MHz
  input wire rst_n_in, // power-on reset, async, active low
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction, 1 = write
  input wire [`KWD_ADDR_W-1:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  input wire [3:0] pstrb_in, // apb byte strobes
  output reg [31:0] prdata_out, // apb read data
  output reg pready_out, // apb ready
  output reg pslverr_out, // apb error, unmapped address
  output reg wd_reset_out // processor reset request, active high
);

  // step size for one oscillator tick, scaled by the selector
  function [`KWD_CNT_W-1:0] step_of;
    input [2:0] sel;
    begin
      step_of = 16'h0001 << (`KWD_PS_MAX - sel);
    end
  endfunction

  // address decode shared by read and write paths
  function [3:0] decode;
    input [`KWD_ADDR_W-1:0] addr;
    begin
      decode = 4'h0;
      case (addr)
        `KWD_KEY_OFS: decode = 4'h1;
        `KWD_CTL_OFS: decode = 4'h2;
        `KWD_SYS_OFS: decode = 4'h4;
        `KWD_STAT_OFS: decode = 4'h8;
        default: decode = 4'h0;
      endcase
    end
  endfunction

  // register state
  reg ctl_en_reg;
  reg ctl_en_next;
  reg [2:0] ctl_ps_reg;
  reg [2:0] ctl_ps_next;
  reg wdr_flag_reg;
  reg wdr_flag_next;
  reg [`KWD_CNT_W-1:0] cnt_reg;
  reg [`KWD_CNT_W-1:0] cnt_next;
  reg [3:0] rst_cnt_reg;
  reg [3:0] rst_cnt_next;

  // bus-side next values and the processor reset request next value
  reg [31:0] rdata_next;
  reg pready_next;
  reg pslverr_next;
  reg wd_reset_next;

  wire tick;
  wire unlocked;
  wire key_pending;
  wire setup_phase;
  wire access_done;
  wire [3:0] sel_dec;
  wire wr_ok;
  wire key_wr;
  wire ctl_wr;
  wire sys_wr;
  wire clr_req;
  wire [`KWD_CNT_W:0] cnt_sum;
  wire overflow;

  // oscillator tick divider
  kwd_tick_gen #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick)
  );

  // key sequence tracker
  kwd_key_lock u_key (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .key_wr_in(key_wr),
    .key_data_in(pwdata_in[7:0]),
    .relock_in(overflow),
    .unlocked_out(unlocked),
    .pending_out(key_pending)
  );

  // apb phase decode; a write lands only on the edge that sees pready high
  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign sel_dec = decode(paddr_in);
  assign wr_ok = access_done & pwrite_in & pstrb_in[0] & ~pslverr_out;
  assign key_wr = wr_ok & sel_dec[0];
  assign ctl_wr = wr_ok & sel_dec[1] & unlocked;
  assign sys_wr = wr_ok & sel_dec[2];
  assign clr_req = ctl_wr & pwdata_in[`KWD_CTL_CLR];

  // counter advance, step picks the timeout
  assign cnt_sum = {1'b0, cnt_reg} + {1'b0, step_of(ctl_ps_reg)};
  assign overflow = ctl_en_reg & tick & cnt_sum[`KWD_CNT_W] & ~clr_req;

  // control register next values; unused bits 6, 4, 3 are dropped
  always @* begin
    ctl_en_next = ctl_en_reg;
    ctl_ps_next = ctl_ps_reg;
    if (overflow) begin
      ctl_en_next = 1'b0;
    end else if (ctl_wr) begin
      ctl_en_next = pwdata_in[`KWD_CTL_EN];
      ctl_ps_next = pwdata_in[`KWD_CTL_PS_HI:`KWD_CTL_PS_LO];
    end
  end

  // counter next value
  always @* begin
    cnt_next = cnt_reg;
    if (clr_req) begin
      cnt_next = {`KWD_CNT_W{1'b0}};
    end else if (overflow) begin
      cnt_next = {`KWD_CNT_W{1'b0}};
    end else if (ctl_en_reg & tick) begin
      cnt_next = cnt_sum[`KWD_CNT_W-1:0];
    end
  end

  // reset cause flag: hardware set wins over a software clear
  always @* begin
    wdr_flag_next = wdr_flag_reg;
    if (overflow) begin
      wdr_flag_next = 1'b1;
    end else if (sys_wr & ~pwdata_in[`KWD_SYS_WDR]) begin
      wdr_flag_next = 1'b0;
    end
  end

  // processor reset pulse length
  always @* begin
    rst_cnt_next = rst_cnt_reg;
    if (overflow) begin
      rst_cnt_next = `KWD_RST_PULSE;
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_next = rst_cnt_reg - 4'h1;
    end
    wd_reset_next = (rst_cnt_next != 4'h0);
  end

  // read data and answer, prepared in the setup cycle
  always @* begin
    rdata_next = prdata_out;
    pready_next = 1'b0;
    pslverr_next = pslverr_out;
    if (setup_phase) begin
      pready_next = 1'b1;
      pslverr_next = (sel_dec == 4'h0);
      rdata_next = 32'h0000_0000;
      if (!pwrite_in) begin
        case (sel_dec)
          4'h2: begin
            rdata_next[`KWD_CTL_EN] = ctl_en_reg;
            rdata_next[`KWD_CTL_PS_HI:`KWD_CTL_PS_LO] = ctl_ps_reg;
          end
          4'h4: begin
            rdata_next[`KWD_SYS_WDR] = wdr_flag_reg;
          end
          4'h8: begin
            rdata_next[`KWD_CNT_W-1:0] = cnt_reg;
            rdata_next[`KWD_STAT_UNLK] = unlocked;
            rdata_next[`KWD_STAT_UNLK+1] = key_pending;
          end
          default: begin
            rdata_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // watchdog state; only the power-on reset touches it
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_en_reg <= `KWD_CTL_EN_RST;
      ctl_ps_reg <= `KWD_CTL_PS_RST;
      cnt_reg <= {`KWD_CNT_W{1'b0}};
      wdr_flag_reg <= `KWD_SYS_WDR_RST;
      rst_cnt_reg <= 4'h0;
      wd_reset_out <= 1'b0;
    end else begin
      ctl_en_reg <= ctl_en_next;
      ctl_ps_reg <= ctl_ps_next;
      cnt_reg <= cnt_next;
      wdr_flag_reg <= wdr_flag_next;
      rst_cnt_reg <= rst_cnt_next;
      wd_reset_out <= wd_reset_next;
    end
  end

  // apb answer registers
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out <= rdata_next;
      pready_out <= pready_next;
      pslverr_out <= pslverr_next;
    end
  end

endmodule

// >>> design/kwd_defines.vh
// constants for the keyed watchdog timer: offsets, fields, reset values, timing
// Notes on behaviour
// - sixteen-bit counter stepped by its own 250 kHz oscillator tick while enabled
// - on overflow reset the processor, set the cause flag, clear enable
// - control register read-only until key writes 0x1e then 0xe1
// - key writes 0xe1 then 0x1e make the control register read-only again
// - control bit 7 enables the watchdog: 0 off, 1 on
// - once enabled the counter counts oscillator ticks scaled by the prescale selector
// - writing 1 to control bit 5 zeroes the counter and restarts counting
// - selector bits 2:0 set timeout, 000 about 2.05 ms, doubling to 262.14 ms
// - control bits 6, 4 and 3 are unused and change nothing
`ifndef KWD_DEFINES_VH
`define KWD_DEFINES_VH

// apb register byte offsets
`define KWD_ADDR_W 12
`define KWD_KEY_OFS 12'h000
`define KWD_CTL_OFS 12'h004
`define KWD_SYS_OFS 12'h008
`define KWD_STAT_OFS 12'h00c

// key values
`define KWD_KEY_A 8'h1e
`define KWD_KEY_B 8'he1

// control register fields
`define KWD_CTL_EN 7
`define KWD_CTL_CLR 5
`define KWD_CTL_PS_HI 2
`define KWD_CTL_PS_LO 0
`define KWD_CTL_EN_RST 1'b0
`define KWD_CTL_PS_RST 3'h0

// system control register fields
`define KWD_SYS_WDR 7
`define KWD_SYS_WDR_RST 1'b0

// status register fields
`define KWD_STAT_UNLK 16

// timing
`define KWD_CLK_HZ 125000000
`define KWD_OSC_HZ 250000
`define KWD_OSC_DIV (`KWD_CLK_HZ / `KWD_OSC_HZ)
`define KWD_CNT_W 16
`define KWD_PS_MAX 3'h7
`define KWD_RST_PULSE 4'h8

`endif

// >>> design/kwd_tick_gen.v
// divider making the one-cycle oscillator tick from the system clock
`include "kwd_defines.vh"

module kwd_tick_gen #(
  parameter DIV = `KWD_OSC_DIV
) (
  input wire clk_in, // system clock
  input wire rst_n_in, // async reset, active low
  output reg tick_out // one-cycle pulse at oscillator rate
);

  reg [15:0] div_reg;
  reg [15:0] div_next;
  wire div_end;

  assign div_end = (div_reg == DIV[15:0] - 16'h0001);

  // next divider count, wrapping at the period
  always @* begin
    if (div_end) begin
      div_next = 16'h0000;
    end else begin
      div_next = div_reg + 16'h0001;
    end
  end

  // free-running divider, independent of the watchdog state
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_out <= div_end;
    end
  end

endmodule

// >>> design/kwd_key_lock.v
// key sequence tracker guarding writes to the control register
`include "kwd_defines.vh"

module kwd_key_lock (
  input wire clk_in, // system clock
  input wire rst_n_in, // async reset, active low
  input wire key_wr_in, // one-cycle key register write
  input wire [7:0] key_data_in, // key value written
  input wire relock_in, // watchdog reset forces read-only
  output reg unlocked_out, // control register writable
  output wire pending_out // first key of a sequence seen
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_UNL1 = 3'b010;
  localparam [2:0] ST_LCK1 = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg unlocked_next;

  assign pending_out = ~state_reg[0];

  // sequence decoding on each key write
  always @* begin
    state_next = state_reg;
    unlocked_next = unlocked_out;
    if (relock_in) begin
      state_next = ST_IDLE;
      unlocked_next = 1'b0;
    end else if (key_wr_in) begin
      case (state_reg)
        ST_IDLE: begin
          if (key_data_in == `KWD_KEY_A) begin
            state_next = ST_UNL1;
          end else if (key_data_in == `KWD_KEY_B) begin
            state_next = ST_LCK1;
          end
        end
        ST_UNL1: begin
          state_next = ST_IDLE;
          if (key_data_in == `KWD_KEY_B) begin
            unlocked_next = 1'b1;
          end
        end
        ST_LCK1: begin
          state_next = ST_IDLE;
          if (key_data_in == `KWD_KEY_A) begin
            unlocked_next = 1'b0;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // state and protection flag, read-only after reset
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      unlocked_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      unlocked_out <= unlocked_next;
    end
  end

endmodule

// >>> verif/kwd_monitor.sv
// port-level assertions for the keyed watchdog timer
`include "kwd_defines.vh"
module kwd_monitor (
  input wire clk_in, // system clock
  input wire rst_n_in, // async reset, active low
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction
  input wire [`KWD_ADDR_W-1:0] paddr_in, // apb address
  input wire [31:0] prdata_out, // read data
  input wire pready_out, // ready
  input wire pslverr_out, // error
  input wire wd_reset_out // processor reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // apb handshake shape
  property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_why; pready_out |-> $past(psel_in && !penable_in); endproperty
  a_why: assert property (p_why) else $error("ready without setup");
  property p_err; pready_out && paddr_in > 12'h00c |-> pslverr_out; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped address");
  property p_ok;
    pready_out && paddr_in[11:4] == 8'h00 && paddr_in[1:0] == 2'h0 |-> !pslverr_out;
  endproperty
  a_ok: assert property (p_ok) else $error("error on mapped address");
  // read data field shapes
  property p_ctl;
    pready_out && !pwrite_in && paddr_in == 12'h004 |-> (prdata_out & 32'hffffff78) == 0;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control unused bits set");
  property p_sys;
    pready_out && !pwrite_in && paddr_in == 12'h008 |-> (prdata_out & 32'hffffff7f) == 0;
  endproperty
  a_sys: assert property (p_sys) else $error("system control extra bits");
  // processor reset pulse length
  property p_pulse; $rose(wd_reset_out) |-> wd_reset_out [*8] ##1 !wd_reset_out; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length wrong");
endmodule

// >>> verif/test_keyed_watchdog_timer.sv
// self-checking bench for the keyed watchdog timer
`include "kwd_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_keyed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [`KWD_ADDR_W-1:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hf;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, wd_reset_out;
  int n_fail = 0, checked = 0, rst_seen = 0;
  logic [32:0] exp_q[$];
  logic [32:0] got, exp;
  kwd_watchdog #(.OSC_DIV(DIV)) u_kwd_watchdog(.clk_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
    .wd_reset_out);
  initial forever #4 clk_in = ~clk_in;
  // count cycles of processor reset
  always @(posedge clk_in) if (wd_reset_out === 1'b1) rst_seen++;
  // compare each read answer with the oldest note
  always @(posedge clk_in)
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
      got = {pslverr_out, prdata_out};
      exp = exp_q.size() ? exp_q.pop_front() : 33'hx;
      `CHK(got, exp)
    end
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(negedge clk_in); while (pready_out !== 1'b1 && ++k < 20);
    @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic key(input logic [7:0] x, input logic [7:0] y);
    wr(12'h000, {24'h0, x});
    wr(12'h000, {24'h0, y});
  endtask
  task automatic waitr(output int c);
    c = 0;
    while (wd_reset_out !== 1'b1 && c < 9000) begin
      @(negedge clk_in);
      c++;
    end
  endtask
  // main sequence
  initial begin
    int r, c;
    void'($urandom(67));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) rd(12'(i * 4), 33'h0);
    wr(12'h004, 32'h87);
    rd(12'h004, 33'h0);
    r = 32'h20 + $urandom_range(95, 0);
    key(8'h1e, 8'(r));
    wr(12'h004, 32'h87);
    rd(12'h004, 33'h0);
    key(8'h1e, 8'he1);
    rd(12'h00c, 33'h10000);
    wr(12'h004, 32'h5a);
    rd(12'h004, 33'h02);
    key(8'he1, 8'h1e);
    wr(12'h004, 32'h80);
    rd(12'h004, 33'h02);
    key(8'h1e, 8'he1);
    wr(12'h004, 32'h80);
    repeat (6) begin
      repeat (1500) @(posedge clk_in);
      wr(12'h004, 32'ha0);
    end
    `CHK(rst_seen, 0)
    for (int s = 0; s < 2; s++) begin
      if (s) begin
        key(8'h1e, 8'he1);
        wr(12'h004, 32'h81);
      end
      waitr(c);
      `CHK(c >= (512 << s) * DIV - DIV && c <= (512 << s) * DIV + DIV + 2, 1'b1)
      repeat (12) @(negedge clk_in);
      `CHK(rst_seen, 8 * (s + 1))
      rd(12'h008, 33'h80);
      rd(12'h00c, 33'h0);
    end
    repeat (3000) @(posedge clk_in);
    `CHK(rst_seen, 16)
    wr(12'h008, 32'h0);
    rd(12'h008, 33'h0);
    rd(12'h010, 33'h100000000);
    close_out;
  end
  // hang guard
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule
bind kwd_watchdog kwd_monitor u_kwd_monitor(.clk_in, .rst_n_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .wd_reset_out);
